// >>> hw/tsc_pkg.sv
// Purpose: shared constants and types for the touch controller
//          reset and startup sequencer, device end and host end
// Assumes: one 100 MHz clock on both ends
// Notes:   times are kept in their own unit, counts derived from them
package tsc_pkg;

    localparam int CLK_PERIOD_NS  = 10;
    localparam int CYC_PER_MS     = 1000000 / CLK_PERIOD_NS;

    // least reset pulse, rounded up to whole cycles
    localparam int RST_MIN_NS     = 90;
    localparam int RST_MIN_CYC    =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // startup delays after hardware and software reset
    localparam int HW_READY_MS    = 135;
    localparam int SW_READY_MS    = 165;
    localparam int MAX_HW_READY_MS = 450;
    localparam int SELF_TEST_MS   = MAX_HW_READY_MS - HW_READY_MS;
    localparam int NOTIFY_FLOAT_MS = 100;
    localparam int IO_LAG_MAX_MS  = 10;

    localparam int HW_READY_CYC   = HW_READY_MS * CYC_PER_MS;
    localparam int SW_READY_CYC   = SW_READY_MS * CYC_PER_MS;
    localparam int SELF_TEST_CYC  = SELF_TEST_MS * CYC_PER_MS;
    localparam int NOTIFY_FLOAT_CYC = NOTIFY_FLOAT_MS * CYC_PER_MS;
    localparam int IO_LAG_MAX_CYC = IO_LAG_MAX_MS * CYC_PER_MS;

    // host side supply ramp allowances
    localparam int ANALOG_LAG_CYC = 1000;
    localparam int SETTLE_CYC     = 1000;

    localparam int CNT_W          = 32;
    localparam int RST_CNT_W      = 8;

    // device link inputs after the synchroniser
    localparam int DEV_IN_W       = 6;
    localparam logic [5:0] DEV_IN_RST = 6'h00;
    localparam int HOST_IN_W      = 3;
    localparam logic [2:0] HOST_IN_RST = 3'h6;

    typedef enum logic [2:0] {
        TSC_HOLD,
        TSC_FLOAT,
        TSC_BOOT,
        TSC_TEST,
        TSC_RUN
    } tsc_dev_st_t;

    typedef enum logic [2:0] {
        TSC_H_OFF,
        TSC_H_CORE,
        TSC_H_SETTLE,
        TSC_H_RUN,
        TSC_H_PULSE
    } tsc_host_st_t;

endpackage

// >>> hw/tsc_link_if.sv
// Purpose: link between host controller and touch controller
// Assumes: notify lines are open drain with pull-ups to io supply
// Notes:   wire level is resolved here from the device enables
`timescale 1ns/1ns
interface tsc_link_if;
    logic reset_n;
    logic sw_reset;
    logic msg_ack;
    logic core_supply_ok;
    logic analog_supply_ok;
    logic io_supply_ok;
    logic notify_i2c_o;
    logic notify_i2c_oe_n;
    logic notify_spi_o;
    logic notify_spi_oe_n;
    logic reset_flag;
    logic host_notify_i2c_n;
    logic host_notify_spi_n;

    // pull-up wins while the device leaves the line as input
    assign host_notify_i2c_n = notify_i2c_oe_n ? 1'b1 : notify_i2c_o;
    assign host_notify_spi_n = notify_spi_oe_n ? 1'b1 : notify_spi_o;

    modport device (
        input  reset_n, sw_reset, msg_ack,
        input  core_supply_ok, analog_supply_ok, io_supply_ok,
        output notify_i2c_o, notify_i2c_oe_n,
        output notify_spi_o, notify_spi_oe_n, reset_flag
    );

    modport host (
        output reset_n, sw_reset, msg_ack,
        output core_supply_ok, analog_supply_ok, io_supply_ok,
        input  host_notify_i2c_n, host_notify_spi_n, reset_flag
    );
endinterface

// >>> hw/tsc_sync.sv
// Purpose: two flip-flop synchroniser for a group of levels
// Assumes: each bit is an independent level
// Notes:   reset value is a constant chosen by the instance
`timescale 1ns/1ns
module tsc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         sys_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } tsc_sync_st_t;

    tsc_sync_st_t q_ff;
    tsc_sync_st_t nxt_q;

    if (W < 1) begin : g_chk
        $error("tsc_sync width must be at least one");
    end

    always_comb begin
        nxt_q      = q_ff;
        nxt_q.meta = async_in;
        nxt_q.sync = q_ff.meta;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_ff <= {RST_VAL, RST_VAL};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sync_out = q_ff.sync;
endmodule

// >>> hw/tsc_dev_end.sv
// Purpose: touch controller reset and startup sequencer, device end
// Assumes: core supply good acts as the internal power-on reset
// Notes:   long delays are parameters so simulation can shorten them
// Functional notes
// [RQ1] host holds reset low while supplies ramp
// [RQ2] host releases reset after supplies nominal
// [RQ3] io supply never enabled after core supply
// [RQ4] ready 135 to 450 ms after power-up
// [RQ5] init stalls and stays silent without supplies
// [RQ6] late analog supply needs host recovery
// [RQ7] reset needs low pulse of 90 ns
// [RQ8] ready 135 to 450 ms after pin release
// [RQ9] software reset, ready 165 to 480 ms later
// [RQ10] reset flag set when reset completes
// [RQ11] notify lines driven low after reset
// [RQ12] notify lines float about 100 ms
// [RQ13] optional power-on self test runs
// [RQ14] io supply within 10 ms of core
// [RQ15] internal power-on reset boots delayed io case
// [RQ16] host controls supplies and reset line
// [RQ17] internal reset held until both released
`timescale 1ns/1ns
module tsc_dev_end
    import tsc_pkg::*;
#(
    parameter int HW_READY_CYCLES  = HW_READY_CYC,
    parameter int SW_READY_CYCLES  = SW_READY_CYC,
    parameter int SELF_TEST_CYCLES = SELF_TEST_CYC,
    parameter int FLOAT_CYCLES     = NOTIFY_FLOAT_CYC
) (
    input  wire logic  sys_clk_in,
    input  wire logic  arst_n_in,
    tsc_link_if.device link,
    input  wire logic  spi_notify_en_in,
    input  wire logic  self_test_en_in,
    output logic       ready_out,
    output logic       self_test_run_out,
    output logic       reset_flag_out
);
    typedef struct packed {
        tsc_dev_st_t          st;
        logic [CNT_W-1:0]     cnt;
        logic [RST_CNT_W-1:0] low_cnt;
        logic                 pin_rst;
        logic                 sw_prev;
        logic                 sw_boot;
        logic                 flag;
        logic                 i2c_o;
        logic                 i2c_oe_n;
        logic                 spi_o;
        logic                 spi_oe_n;
        logic                 ready;
        logic                 test_run;
    } tsc_dev_q_t;

    tsc_dev_q_t       q_ff;
    tsc_dev_q_t       nxt_q;
    logic [DEV_IN_W-1:0] raw_in;
    logic [DEV_IN_W-1:0] syn_in;
    logic             rst_pin_n;
    logic             sw_lvl;
    logic             ack_lvl;
    logic             core_ok;
    logic             analog_ok;
    logic             io_ok;
    logic             all_ok;
    logic             sw_cmd;
    logic             por;
    logic [CNT_W-1:0] boot_end;

    if (FLOAT_CYCLES < 1 || HW_READY_CYCLES <= FLOAT_CYCLES ||
        SW_READY_CYCLES <= FLOAT_CYCLES || SELF_TEST_CYCLES < 1) begin : g_chk
        $error("tsc_dev_end delay parameters out of range");
    end
    if (RST_MIN_CYC >= (1 << RST_CNT_W)) begin : g_chk_rst
        $error("tsc_dev_end reset filter counter too narrow");
    end

    assign raw_in = {link.reset_n, link.sw_reset, link.msg_ack,
                     link.core_supply_ok, link.analog_supply_ok,
                     link.io_supply_ok};

    tsc_sync #(
        .W       (DEV_IN_W),
        .RST_VAL (DEV_IN_RST)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .async_in   (raw_in),
        .sync_out   (syn_in)
    );

    assign rst_pin_n = syn_in[5];
    assign sw_lvl    = syn_in[4];
    assign ack_lvl   = syn_in[3];
    assign core_ok   = syn_in[2];
    assign analog_ok = syn_in[1];
    assign io_ok     = syn_in[0];

    always_comb begin
        nxt_q    = q_ff;
        all_ok   = core_ok & analog_ok & io_ok;
        // [RQ15] core supply loss acts as power-on reset
        por      = ~core_ok;
        sw_cmd   = sw_lvl & ~q_ff.sw_prev;
        boot_end = q_ff.sw_boot ? CNT_W'(SW_READY_CYCLES - 1)
                                : CNT_W'(HW_READY_CYCLES - 1);
        nxt_q.sw_prev = sw_lvl;

        // [RQ7] ignore pin lows shorter than minimum
        if (rst_pin_n) begin
            nxt_q.low_cnt = '0;
            nxt_q.pin_rst = 1'b0;
        end else if (q_ff.low_cnt < RST_CNT_W'(RST_MIN_CYC)) begin
            nxt_q.low_cnt = q_ff.low_cnt + RST_CNT_W'(1);
            nxt_q.pin_rst = q_ff.pin_rst ||
                (q_ff.low_cnt + RST_CNT_W'(1)) >= RST_CNT_W'(RST_MIN_CYC);
        end

        case (q_ff.st)
            TSC_HOLD: begin
                nxt_q.cnt = '0;
                // [RQ17] wait for both resets released
                if (!por && !q_ff.pin_rst) begin
                    nxt_q.st = TSC_FLOAT;
                end
            end
            TSC_FLOAT: begin
                // [RQ5] count stalls while a supply is missing
                if (all_ok) begin
                    nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                    // [RQ12] lines left as inputs this long
                    if (q_ff.cnt == CNT_W'(FLOAT_CYCLES - 1)) begin
                        nxt_q.st       = TSC_BOOT;
                        nxt_q.i2c_o    = 1'b1;
                        nxt_q.i2c_oe_n = 1'b0;
                        nxt_q.spi_o    = 1'b1;
                        nxt_q.spi_oe_n = ~spi_notify_en_in;
                    end
                end
            end
            TSC_BOOT: begin
                // [RQ5] silent toward host while stalled
                nxt_q.i2c_oe_n = ~all_ok;
                nxt_q.spi_oe_n = ~(all_ok & spi_notify_en_in);
                if (all_ok) begin
                    nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                    // [RQ8] startup delay ends here
                    if (q_ff.cnt >= boot_end) begin
                        nxt_q.cnt = '0;
                        // [RQ13] optional self test before ready
                        if (self_test_en_in) begin
                            nxt_q.st       = TSC_TEST;
                            nxt_q.test_run = 1'b1;
                        end else begin
                            nxt_q.st = TSC_RUN;
                        end
                    end
                end
            end
            TSC_TEST: begin
                nxt_q.i2c_oe_n = ~all_ok;
                nxt_q.spi_oe_n = ~(all_ok & spi_notify_en_in);
                if (all_ok) begin
                    nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                    // [RQ4] self test stretches to the upper bound
                    if (q_ff.cnt == CNT_W'(SELF_TEST_CYCLES - 1)) begin
                        nxt_q.st       = TSC_RUN;
                        nxt_q.test_run = 1'b0;
                    end
                end
            end
            TSC_RUN: begin
                nxt_q.i2c_oe_n = 1'b0;
                nxt_q.spi_oe_n = ~spi_notify_en_in;
                // host read of the message clears flag and lines
                if (ack_lvl) begin
                    nxt_q.flag  = 1'b0;
                    nxt_q.i2c_o = 1'b1;
                    nxt_q.spi_o = 1'b1;
                end
            end
            default: begin
                nxt_q.st = TSC_HOLD;
            end
        endcase

        // entry into run: flag set wins over an ack this cycle
        if (q_ff.st != TSC_RUN && nxt_q.st == TSC_RUN) begin
            nxt_q.ready = 1'b1;
            // [RQ10] reset complete flag
            nxt_q.flag  = 1'b1;
            // [RQ11] announce pending message
            nxt_q.i2c_o = 1'b0;
            nxt_q.spi_o = 1'b0;
        end

        // [RQ9] software command restarts the sequence
        if (por || nxt_q.pin_rst || sw_cmd) begin
            nxt_q.st       = TSC_HOLD;
            nxt_q.cnt      = '0;
            nxt_q.sw_boot  = sw_cmd & ~por & ~nxt_q.pin_rst;
            nxt_q.flag     = 1'b0;
            nxt_q.ready    = 1'b0;
            nxt_q.test_run = 1'b0;
            // [RQ12] lines released during reset
            nxt_q.i2c_o    = 1'b1;
            nxt_q.i2c_oe_n = 1'b1;
            nxt_q.spi_o    = 1'b1;
            nxt_q.spi_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_ff.st       <= TSC_HOLD;
            q_ff.cnt      <= '0;
            q_ff.low_cnt  <= '0;
            q_ff.pin_rst  <= 1'b1;
            q_ff.sw_prev  <= 1'b0;
            q_ff.sw_boot  <= 1'b0;
            q_ff.flag     <= 1'b0;
            q_ff.i2c_o    <= 1'b1;
            q_ff.i2c_oe_n <= 1'b1;
            q_ff.spi_o    <= 1'b1;
            q_ff.spi_oe_n <= 1'b1;
            q_ff.ready    <= 1'b0;
            q_ff.test_run <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign link.notify_i2c_o    = q_ff.i2c_o;
    assign link.notify_i2c_oe_n = q_ff.i2c_oe_n;
    assign link.notify_spi_o    = q_ff.spi_o;
    assign link.notify_spi_oe_n = q_ff.spi_oe_n;
    assign link.reset_flag      = q_ff.flag;
    assign ready_out            = q_ff.ready;
    assign self_test_run_out    = q_ff.test_run;
    assign reset_flag_out       = q_ff.flag;
endmodule

// >>> hw/tsc_host_end.sv
// Purpose: host controller end: supplies, reset pin, notify watch
// Assumes: one supply enable stands for the supply being nominal
// Notes:   host never drives the notify lines
`timescale 1ns/1ns
module tsc_host_end
    import tsc_pkg::*;
#(
    parameter int ANALOG_LAG_CYCLES = ANALOG_LAG_CYC,
    parameter int SETTLE_CYCLES     = SETTLE_CYC,
    parameter int RST_PULSE_CYCLES  = RST_MIN_CYC
) (
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    tsc_link_if.host  link,
    input  wire logic power_on_in,
    input  wire logic hw_reset_req_in,
    input  wire logic sw_reset_req_in,
    input  wire logic msg_ack_req_in,
    output logic      seq_done_out,
    output logic      dev_notify_out,
    output logic      reset_flag_out
);
    typedef struct packed {
        tsc_host_st_t     st;
        logic [CNT_W-1:0] cnt;
        logic             core_en;
        logic             analog_en;
        logic             io_en;
        logic             reset_n;
        logic             sw;
        logic             ack;
        logic             done;
        logic             notify;
        logic             flag;
    } tsc_host_q_t;

    tsc_host_q_t          q_ff;
    tsc_host_q_t          nxt_q;
    logic [HOST_IN_W-1:0] raw_in;
    logic [HOST_IN_W-1:0] syn_in;
    logic                 notify_low;

    if (RST_PULSE_CYCLES < RST_MIN_CYC || ANALOG_LAG_CYCLES < 1 ||
        ANALOG_LAG_CYCLES > IO_LAG_MAX_CYC || SETTLE_CYCLES < 1) begin : g_chk
        $error("tsc_host_end timing parameters out of range");
    end

    assign raw_in = {link.host_notify_i2c_n, link.host_notify_spi_n,
                     link.reset_flag};

    tsc_sync #(
        .W       (HOST_IN_W),
        .RST_VAL (HOST_IN_RST)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .async_in   (raw_in),
        .sync_out   (syn_in)
    );

    always_comb begin
        nxt_q       = q_ff;
        notify_low  = ~syn_in[2] | ~syn_in[1];
        nxt_q.sw    = 1'b0;
        nxt_q.ack   = 1'b0;
        nxt_q.notify = notify_low;
        nxt_q.flag  = syn_in[0];
        case (q_ff.st)
            TSC_H_OFF: begin
                nxt_q.cnt = '0;
                if (power_on_in) begin
                    // [RQ3] [RQ14] io and core come up together
                    nxt_q.core_en = 1'b1;
                    nxt_q.io_en   = 1'b1;
                    nxt_q.st      = TSC_H_CORE;
                end
            end
            TSC_H_CORE: begin
                nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                if (q_ff.cnt == CNT_W'(ANALOG_LAG_CYCLES - 1)) begin
                    nxt_q.analog_en = 1'b1;
                    nxt_q.cnt       = '0;
                    nxt_q.st        = TSC_H_SETTLE;
                end
            end
            TSC_H_SETTLE: begin
                nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                // [RQ2] release only after all supplies settled
                if (q_ff.cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
                    nxt_q.reset_n = 1'b1;
                    nxt_q.done    = 1'b1;
                    nxt_q.st      = TSC_H_RUN;
                end
            end
            TSC_H_RUN: begin
                nxt_q.cnt = '0;
                if (hw_reset_req_in) begin
                    // [RQ7] drive a long enough low pulse
                    nxt_q.reset_n = 1'b0;
                    nxt_q.done    = 1'b0;
                    nxt_q.st      = TSC_H_PULSE;
                end else if (sw_reset_req_in) begin
                    // [RQ6] reset command as recovery path
                    nxt_q.sw = 1'b1;
                end else if (msg_ack_req_in && notify_low) begin
                    nxt_q.ack = 1'b1;
                end
            end
            TSC_H_PULSE: begin
                nxt_q.cnt = q_ff.cnt + CNT_W'(1);
                if (q_ff.cnt == CNT_W'(RST_PULSE_CYCLES - 1)) begin
                    nxt_q.reset_n = 1'b1;
                    nxt_q.done    = 1'b1;
                    nxt_q.st      = TSC_H_RUN;
                end
            end
            default: begin
                nxt_q.st = TSC_H_OFF;
            end
        endcase
        // [RQ16] power down pulls reset low with supplies
        if (!power_on_in) begin
            nxt_q.st        = TSC_H_OFF;
            nxt_q.core_en   = 1'b0;
            nxt_q.analog_en = 1'b0;
            nxt_q.io_en     = 1'b0;
            // [RQ1] reset stays low through supply ramp
            nxt_q.reset_n   = 1'b0;
            nxt_q.done      = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign link.reset_n          = q_ff.reset_n;
    assign link.sw_reset         = q_ff.sw;
    assign link.msg_ack          = q_ff.ack;
    assign link.core_supply_ok   = q_ff.core_en;
    assign link.analog_supply_ok = q_ff.analog_en;
    assign link.io_supply_ok     = q_ff.io_en;
    assign seq_done_out          = q_ff.done;
    assign dev_notify_out        = q_ff.notify;
    assign reset_flag_out        = q_ff.flag;
endmodule

// >>> dv/tsc_link_asserts.sv
// Purpose: checks on the host to device link
// Assumes: one clock domain, async active low reset
// Notes:   bounds follow the shortened device counts
`timescale 1ns/1ns
module tsc_link_asserts #(
    parameter int HW_READY_CYCLES  = 300,
    parameter int SW_READY_CYCLES  = 400,
    parameter int SELF_TEST_CYCLES = 200,
    parameter int FLOAT_CYCLES     = 100
) (
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    input  wire logic reset_n,
    input  wire logic sw_reset,
    input  wire logic msg_ack,
    input  wire logic core_supply_ok,
    input  wire logic analog_supply_ok,
    input  wire logic io_supply_ok,
    input  wire logic notify_i2c_oe_n,
    input  wire logic reset_flag,
    input  wire logic host_notify_i2c_n,
    input  wire logic host_notify_spi_n
);
    logic [31:0] float_cnt_ff;
    logic [31:0] run_cnt_ff;
    logic        sw_seen_ff;
    logic [31:0] ready_min;

    // restart points: pin low, core loss or software reset
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            float_cnt_ff <= '0;
            run_cnt_ff   <= '0;
            sw_seen_ff   <= 1'h0;
        end else begin
            float_cnt_ff <= notify_i2c_oe_n ? float_cnt_ff + 32'h1 : '0;
            run_cnt_ff   <= (!reset_n || !core_supply_ok || sw_reset) ?
                            '0 : run_cnt_ff + 32'h1;
            if (sw_reset) begin
                sw_seen_ff <= 1'h1;
            end else if (!reset_n || !core_supply_ok) begin
                sw_seen_ff <= 1'h0;
            end
        end
    end
    // software reset takes the longer delay
    assign ready_min = sw_seen_ff ? 32'(SW_READY_CYCLES) :
                       32'(HW_READY_CYCLES);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence lines_released;
        !reset_flag && notify_i2c_oe_n;
    endsequence
    sequence msg_taken;
        !reset_flag && host_notify_i2c_n && host_notify_spi_n;
    endsequence

    io_with_core_a: assert property (
        $rose(core_supply_ok) |-> io_supply_ok)
        else $error("io supply later than core");
    pin_low_ramp_a: assert property (
        !(core_supply_ok && analog_supply_ok && io_supply_ok) |-> !reset_n)
        else $error("reset pin high before supplies");
    float_length_a: assert property (
        $fell(notify_i2c_oe_n) |-> float_cnt_ff >= FLOAT_CYCLES)
        else $error("notify line driven too early");
    ready_delay_a: assert property (
        $fell(host_notify_i2c_n) |-> run_cnt_ff >= ready_min &&
        run_cnt_ff <= ready_min + 32'(SELF_TEST_CYCLES) + 32'hc)
        else $error("ready delay out of window");
    flag_with_line_a: assert property (
        $rose(reset_flag) |-> !host_notify_i2c_n && !host_notify_spi_n)
        else $error("flag set without notify lines low");
    pin_reset_a: assert property (
        $fell(reset_n) |-> ##[9:12] lines_released)
        else $error("pin reset not taken");
    sw_reset_a: assert property (
        sw_reset |-> ##[2:5] lines_released)
        else $error("software reset not taken");
    ack_clear_a: assert property (
        msg_ack && reset_flag |-> ##[2:5] msg_taken)
        else $error("ack did not clear flag");
endmodule

// >>> dv/tb.sv
// Purpose: bench for both ends joined by the link
// Assumes: shortened counts, inputs change at falling edge
// Notes:   a second device end is driven by the bench
`timescale 1ns/1ns
module tb;
    localparam int HW = 300;
    localparam int SW = 400;
    localparam int ST = 200;
    localparam int FL = 100;
    logic sys_clk, arst_n, power_on, hw_req, sw_req, ack_req, test_en;
    logic seq_done, dev_notify, h_flag, ready, test_run, d_flag, ready2;
    logic spi_en, d_flag2;
    logic [1:0] lines, lines2;
    int   err_count = 0;
    int   samples_checked = 0;
    int   cycles = 0;

    tsc_link_if link ();
    tsc_link_if link2 ();
    assign lines = {link.host_notify_i2c_n, link.host_notify_spi_n};
    assign lines2 = {link2.host_notify_i2c_n, link2.host_notify_spi_n};

    tsc_host_end #(50, 50, 12) tsc_host_end_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .link(link),
        .power_on_in(power_on), .hw_reset_req_in(hw_req),
        .sw_reset_req_in(sw_req), .msg_ack_req_in(ack_req),
        .seq_done_out(seq_done), .dev_notify_out(dev_notify),
        .reset_flag_out(h_flag));
    tsc_dev_end #(HW, SW, ST, FL) tsc_dev_end_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .link(link),
        .spi_notify_en_in(spi_en), .self_test_en_in(test_en),
        .ready_out(ready), .self_test_run_out(test_run),
        .reset_flag_out(d_flag));
    // fault end: bench plays the host on link2
    tsc_dev_end #(HW, SW, ST, FL) tsc_dev_end_fault_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .link(link2),
        .spi_notify_en_in(1'h0), .self_test_en_in(1'h0),
        .ready_out(ready2), .self_test_run_out(),
        .reset_flag_out(d_flag2));
    tsc_link_asserts #(HW, SW, ST, FL) tsc_link_asserts_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .reset_n(link.reset_n),
        .sw_reset(link.sw_reset), .msg_ack(link.msg_ack),
        .core_supply_ok(link.core_supply_ok),
        .analog_supply_ok(link.analog_supply_ok),
        .io_supply_ok(link.io_supply_ok),
        .notify_i2c_oe_n(link.notify_i2c_oe_n),
        .reset_flag(link.reset_flag),
        .host_notify_i2c_n(link.host_notify_i2c_n),
        .host_notify_spi_n(link.host_notify_spi_n));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // bounded wait, so a dead end cannot hang the run
    task automatic wait_ready(input logic lvl, input bit dev2, output int n);
        n = 0;
        while ((dev2 ? ready2 : ready) !== lvl && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic pulse2(input int len);
        link2.reset_n = 1'h0;
        repeat (len) @(negedge sys_clk);
        link2.reset_n = 1'h1;
    endtask

    task automatic power_up();
        int n;
        int highs;
        power_on = 1'h1;
        n = 0;
        while (seq_done !== 1'h1 && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
        highs = 0;
        repeat (FL) begin
            @(negedge sys_clk);
            highs += (link.notify_i2c_oe_n === 1'h1);
        end
        check("float", FL, highs);
        wait_ready(1'h1, 1'h0, n);
        check("hw delay", 1, n >= HW - FL && n <= HW - FL + 8);
        check("lines", 2'h0, lines);
        repeat (6) @(negedge sys_clk);
        check("flags", 3'h7, {d_flag, h_flag, dev_notify});
    endtask

    task automatic ack_test();
        ack_req = 1'h1;
        @(negedge sys_clk);
        ack_req = 1'h0;
        repeat (8) @(negedge sys_clk);
        check("ack lines", 2'h3, lines);
        check("ack flags", 3'h0, {d_flag, h_flag, dev_notify});
    endtask

    // self test on software path only: both delays seen
    task automatic reset_timed(input logic sw, input int exp, input int te);
        int n;
        int t;
        test_en = sw;
        sw_req = sw;
        hw_req = ~sw;
        @(negedge sys_clk);
        sw_req = 1'h0;
        hw_req = 1'h0;
        wait_ready(1'h0, 1'h0, n);
        check("reset seen", 1, n < 16);
        n = 0;
        t = 0;
        while (ready !== 1'h1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
            t += (test_run === 1'h1);
        end
        check("delay", 1, n >= exp && n <= exp + 8);
        check("self test", 1, t + 1 >= te && t <= te + 2);
        check("flag", 1'h1, d_flag);
    endtask

    task automatic por_boot();
        int n;
        link2.reset_n = 1'h1;
        link2.core_supply_ok = 1'h1;
        link2.analog_supply_ok = 1'h1;
        repeat (10) @(negedge sys_clk);
        link2.io_supply_ok = 1'h1;
        wait_ready(1'h1, 1'h1, n);
        check("por delay", 1, n >= HW && n <= HW + 8);
        check("por lines", 2'h1, lines2);
        check("por flag", 1'h1, d_flag2);
    endtask

    task automatic short_pulse();
        int n;
        pulse2(8);
        repeat (20) @(negedge sys_clk);
        check("short pulse", 1'h1, ready2);
        pulse2(9);
        wait_ready(1'h0, 1'h1, n);
        check("min pulse", 1, n < 8);
        wait_ready(1'h1, 1'h1, n);
        check("pin delay", 1, n >= HW && n <= HW + 8);
    endtask

    task automatic missing_supply();
        int n;
        link2.analog_supply_ok = 1'h0;
        pulse2(12);
        repeat (HW + 50) @(negedge sys_clk);
        check("silent", 3'h3, {ready2, lines2});
        link2.analog_supply_ok = 1'h1;
        wait_ready(1'h1, 1'h1, n);
        check("resume", 1, n >= HW && n <= HW + 8);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        arst_n = 1'h0;
        {power_on, hw_req, sw_req, ack_req, test_en, spi_en} = 6'h1;
        {link2.reset_n, link2.sw_reset, link2.msg_ack} = 3'h0;
        {link2.core_supply_ok, link2.analog_supply_ok,
         link2.io_supply_ok} = 3'h0;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'h1;
        power_up();
        ack_test();
        reset_timed(1'h1, SW + ST, ST);
        reset_timed(1'h0, HW, 0);
        por_boot();
        short_pulse();
        missing_supply();
        finish_test();
    end
endmodule
